// ===== core/crs_regs.svh
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// Byte offsets of the register window on the bus
`define CRS_OFS_DATA0 12'h000
`define CRS_OFS_DATA1 12'h004
`define CRS_OFS_DATA2 12'h008
`define CRS_OFS_DATA3 12'h00c
`define CRS_OFS_ADDR0 12'h010
`define CRS_OFS_ADDR1 12'h014
`define CRS_OFS_FRAME 12'h018
`define CRS_OFS_VTB 12'h01c
`define CRS_OFS_PC 12'h020
`define CRS_OFS_USER_SP 12'h024
`define CRS_OFS_IRQ_SP 12'h028
`define CRS_OFS_STATIC 12'h02c
`define CRS_OFS_FLAGS 12'h030

// Flag word bit positions
`define CRS_FLAG_CARRY 0
`define CRS_FLAG_DEBUG 1
`define CRS_FLAG_ZERO 2
`define CRS_FLAG_SIGN 3
`define CRS_FLAG_BANK 4
`define CRS_FLAG_OVF 5
`define CRS_FLAG_STACK 7

`define CRS_FLAG_RESET 11'h000
`define CRS_W16_RESET 16'h0000
`define CRS_W20_RESET 20'h00000
`define CRS_W32_ZERO 32'h0000_0000

`endif

// ===== core/crs_pkg.sv
package crs_pkg;
  typedef logic [15:0] crs_word_t;
  typedef logic [19:0] crs_addr_t;
  typedef logic [10:0] crs_flags_t;
  // Register selector used by the datapath write and read ports
  typedef enum logic [3:0] {
    CRS_SEL_DATA0 = 4'h0,
    CRS_SEL_DATA1 = 4'h1,
    CRS_SEL_DATA2 = 4'h2,
    CRS_SEL_DATA3 = 4'h3,
    CRS_SEL_ADDR0 = 4'h4,
    CRS_SEL_ADDR1 = 4'h5,
    CRS_SEL_FRAME = 4'h6,
    CRS_SEL_USER_SP = 4'h7,
    CRS_SEL_IRQ_SP = 4'h8,
    CRS_SEL_STATIC = 4'h9,
    CRS_SEL_SP = 4'ha
  } crs_sel_e;
  // Byte-write lane select for the two splittable data registers
  typedef enum logic [1:0] {
    CRS_LANE_WORD = 2'h0,
    CRS_LANE_LOW = 2'h1,
    CRS_LANE_HIGH = 2'h3
  } crs_lane_e;
  // AHB data-phase tracker
  typedef enum logic [1:0] {
    CRS_BUS_IDLE = 2'h0,
    CRS_BUS_WRITE = 2'h1,
    CRS_BUS_READ = 2'h3
  } crs_bus_e;
endpackage : crs_pkg

// ===== core/crs_register_set.sv
`timescale 1ns/100ps
`include "crs_regs.svh"
// How it works
// [RULE1] Thirteen registers; seven form one bank
// [RULE2] Two banks, bank flag picks one
// [RULE3] Data registers 16-bit; first two split bytes
// [RULE4] Data 2:0 and 3:1 form 32-bit pairs
// [RULE5] Address registers 16-bit, pair 1:0 32-bit
// [RULE6] Frame base is 16-bit frame pointer
// [RULE7] Vector table base is 20-bit
// [RULE8] Program counter is 20-bit next address
// [RULE9] Two stack pointers, stack flag selects
// [RULE10] Static base is 16-bit base pointer
// [RULE11] Flag word is 11-bit status register
// [RULE12] Carry takes ALU carry, borrow, shift-out
// [RULE13] Debug flag kept zero by software
// [RULE14] Zero flag set on zero result
// [RULE15] Sign flag set on negative result
// [RULE16] Overflow flag set on signed overflow
// [RULE17] Fixed flag positions; reset clears whole word
module crs_register_set (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Datapath write port
  input wire logic dp_wr_en,
  input wire crs_pkg::crs_sel_e dp_wr_sel,
  input wire crs_pkg::crs_lane_e dp_wr_lane,
  input wire crs_pkg::crs_word_t dp_wr_data,
  // Datapath 32-bit pair writes
  input wire logic dp_pair_wr_en,
  input wire logic [1:0] dp_pair_sel,
  input wire logic [31:0] dp_pair_data,
  // Program counter and vector base
  input wire logic pc_load,
  input wire crs_pkg::crs_addr_t pc_next,
  input wire logic vtb_load,
  input wire crs_pkg::crs_addr_t vtb_next,
  // Flag word updates from the ALU
  input wire logic alu_flags_en,
  input wire logic alu_carry,
  input wire crs_pkg::crs_word_t alu_result,
  input wire logic alu_byte,
  input wire logic alu_overflow,
  input wire logic flags_load,
  input wire crs_pkg::crs_flags_t flags_next,
  // Read port
  input wire crs_pkg::crs_sel_e dp_rd_sel,
  output crs_pkg::crs_word_t dp_rd_data,
  output logic [31:0] data_pair_low_32,
  output logic [31:0] data_pair_high_32,
  output logic [31:0] addr_pair_32,
  output crs_pkg::crs_addr_t program_counter,
  output crs_pkg::crs_addr_t vector_table_base,
  output crs_pkg::crs_word_t frame_base,
  output crs_pkg::crs_word_t static_base,
  output crs_pkg::crs_word_t active_stack_ptr,
  output crs_pkg::crs_flags_t cpu_flags
);
  import crs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: banked set indexed by bank and slot
  crs_word_t bank_regs [0:1][0:6]; // [RULE1] [RULE2]
  crs_word_t user_stack_ptr;
  crs_word_t irq_stack_ptr;
  crs_word_t static_base_q;
  crs_addr_t pc_q;
  crs_addr_t vtb_q;
  crs_flags_t flags_q;
  logic bank;
  logic sp_sel;

  // Bus data-phase state
  crs_bus_e bus_state;
  logic [11:0] bus_addr;

  assign bank = flags_q[`CRS_FLAG_BANK]; // [RULE2]
  assign sp_sel = flags_q[`CRS_FLAG_STACK]; // [RULE9]

  ////////////////////////////////////////////////////////////////////////////
  // Bus write decode: returns selector for an offset, or no hit
  function automatic logic [4:0] crs_decode(input logic [11:0] a);
    logic [4:0] r;
    r = 5'h1f;
    case (a)
      `CRS_OFS_DATA0: r = 5'h00;
      `CRS_OFS_DATA1: r = 5'h01;
      `CRS_OFS_DATA2: r = 5'h02;
      `CRS_OFS_DATA3: r = 5'h03;
      `CRS_OFS_ADDR0: r = 5'h04;
      `CRS_OFS_ADDR1: r = 5'h05;
      `CRS_OFS_FRAME: r = 5'h06;
      `CRS_OFS_USER_SP: r = 5'h07;
      `CRS_OFS_IRQ_SP: r = 5'h08;
      `CRS_OFS_STATIC: r = 5'h09;
      `CRS_OFS_VTB: r = 5'h10;
      `CRS_OFS_PC: r = 5'h11;
      `CRS_OFS_FLAGS: r = 5'h12;
      default: r = 5'h1f;
    endcase
    return r;
  endfunction : crs_decode

  // Merge a byte lane into a word
  function automatic crs_word_t crs_merge(input crs_word_t old, input crs_word_t nw,
                                          input crs_lane_e lane);
    crs_word_t r;
    case (lane)
      CRS_LANE_LOW: r = {old[15:8], nw[7:0]};
      CRS_LANE_HIGH: r = {nw[7:0], old[7:0]};
      default: r = nw;
    endcase
    return r;
  endfunction : crs_merge

  logic [4:0] bus_wsel;
  logic bus_wr;
  logic rd_addr;
  logic rd_stall;
  logic rd_take;
  assign bus_wsel = crs_decode(bus_addr);
  assign bus_wr = (bus_state == CRS_BUS_WRITE);

  // A read right behind a write would see the old value, so it waits one
  // cycle for the write to land and is then taken from the held address.
  assign rd_addr = hready && hsel && htrans[1] && !hwrite;
  assign rd_stall = rd_addr && bus_wr;
  assign rd_take = (rd_addr && !bus_wr) || (!hreadyout && bus_state == CRS_BUS_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking; always OKAY
  // A stalled data phase keeps its state until hready returns
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= CRS_BUS_IDLE;
      bus_addr <= 12'h000;
    end else if (hready) begin
      if (hsel && htrans[1]) begin
        bus_state <= hwrite ? CRS_BUS_WRITE : CRS_BUS_READ;
        bus_addr <= haddr;
      end else begin
        bus_state <= CRS_BUS_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !rd_stall;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banked registers: bus write, datapath write, 32-bit pair writes
  // Bus write wins over datapath in the same cycle; software debug access.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int b = 0; b < 2; b++) begin
        for (int s = 0; s < 7; s++) begin
          bank_regs[b][s] <= `CRS_W16_RESET;
        end
      end
    end else if (bus_wr && bus_wsel < 5'h07) begin
      bank_regs[bank][bus_wsel[2:0]] <= hwdata[15:0]; // [RULE2]
    end else if (dp_pair_wr_en) begin
      case (dp_pair_sel)
        2'h0: begin
          bank_regs[bank][2] <= dp_pair_data[31:16]; // [RULE4]
          bank_regs[bank][0] <= dp_pair_data[15:0];
        end
        2'h1: begin
          bank_regs[bank][3] <= dp_pair_data[31:16]; // [RULE4]
          bank_regs[bank][1] <= dp_pair_data[15:0];
        end
        default: begin
          bank_regs[bank][5] <= dp_pair_data[31:16]; // [RULE5]
          bank_regs[bank][4] <= dp_pair_data[15:0];
        end
      endcase
    end else if (dp_wr_en && dp_wr_sel <= CRS_SEL_FRAME) begin
      // Only the first two data registers split into bytes
      if (dp_wr_sel <= CRS_SEL_DATA1) begin
        bank_regs[bank][dp_wr_sel[2:0]] <=
          crs_merge(bank_regs[bank][dp_wr_sel[2:0]], dp_wr_data, dp_wr_lane); // [RULE3]
      end else begin
        bank_regs[bank][dp_wr_sel[2:0]] <= dp_wr_data; // [RULE5] [RULE6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointers and static base
  logic dp_sp_wr;
  assign dp_sp_wr = dp_wr_en && dp_wr_sel == CRS_SEL_SP;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_stack_ptr <= `CRS_W16_RESET;
      irq_stack_ptr <= `CRS_W16_RESET;
    end else if (bus_wr && (bus_wsel == 5'h07 || bus_wsel == 5'h08)) begin
      if (bus_wsel == 5'h07) begin
        user_stack_ptr <= hwdata[15:0];
      end else begin
        irq_stack_ptr <= hwdata[15:0];
      end
    end else if (dp_wr_en) begin
      // Active stack writes follow the stack flag
      if (dp_wr_sel == CRS_SEL_USER_SP || (dp_sp_wr && sp_sel)) begin
        user_stack_ptr <= dp_wr_data; // [RULE9]
      end else if (dp_wr_sel == CRS_SEL_IRQ_SP || (dp_sp_wr && !sp_sel)) begin
        irq_stack_ptr <= dp_wr_data; // [RULE9]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      static_base_q <= `CRS_W16_RESET;
    end else if (bus_wr && bus_wsel == 5'h09) begin
      static_base_q <= hwdata[15:0];
    end else if (dp_wr_en && dp_wr_sel == CRS_SEL_STATIC) begin
      static_base_q <= dp_wr_data; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and vector table base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= `CRS_W20_RESET;
    end else if (bus_wr && bus_wsel == 5'h11) begin
      pc_q <= hwdata[19:0];
    end else if (pc_load) begin
      pc_q <= pc_next; // [RULE8]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vtb_q <= `CRS_W20_RESET;
    end else if (bus_wr && bus_wsel == 5'h10) begin
      vtb_q <= hwdata[19:0];
    end else if (vtb_load) begin
      vtb_q <= vtb_next; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag word. Whole-word load first, then ALU results on top of it.
  crs_flags_t next_flags;
  logic res_zero;
  logic res_neg;
  assign res_zero = alu_byte ? (alu_result[7:0] == 8'h00) : (alu_result == 16'h0000);
  assign res_neg = alu_byte ? alu_result[7] : alu_result[15];

  always_comb begin
    next_flags = flags_q;
    if (bus_wr && bus_wsel == 5'h12) begin
      next_flags = hwdata[10:0]; // [RULE11]
    end else if (flags_load) begin
      next_flags = flags_next;
    end
    // Debug flag is plain storage; the datapath keeps it clear
    if (alu_flags_en) begin
      next_flags[`CRS_FLAG_CARRY] = alu_carry; // [RULE12]
      next_flags[`CRS_FLAG_ZERO] = res_zero; // [RULE14]
      next_flags[`CRS_FLAG_SIGN] = res_neg; // [RULE15]
      next_flags[`CRS_FLAG_OVF] = alu_overflow; // [RULE16]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= `CRS_FLAG_RESET; // [RULE17]
    end else begin
      flags_q <= next_flags; // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; they show state one edge after it changes

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_flags <= `CRS_FLAG_RESET;
      program_counter <= `CRS_W20_RESET;
      vector_table_base <= `CRS_W20_RESET;
      static_base <= `CRS_W16_RESET;
    end else begin
      cpu_flags <= flags_q;
      program_counter <= pc_q;
      vector_table_base <= vtb_q;
      static_base <= static_base_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_pair_low_32 <= `CRS_W32_ZERO;
      data_pair_high_32 <= `CRS_W32_ZERO;
      addr_pair_32 <= `CRS_W32_ZERO;
      frame_base <= `CRS_W16_RESET;
      active_stack_ptr <= `CRS_W16_RESET;
    end else begin
      data_pair_low_32 <= {bank_regs[bank][2], bank_regs[bank][0]}; // [RULE4]
      data_pair_high_32 <= {bank_regs[bank][3], bank_regs[bank][1]}; // [RULE4]
      addr_pair_32 <= {bank_regs[bank][5], bank_regs[bank][4]}; // [RULE5]
      frame_base <= bank_regs[bank][6]; // [RULE6]
      active_stack_ptr <= sp_sel ? user_stack_ptr : irq_stack_ptr; // [RULE9]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd_data <= `CRS_W16_RESET;
    end else begin
      case (dp_rd_sel)
        CRS_SEL_USER_SP: dp_rd_data <= user_stack_ptr;
        CRS_SEL_IRQ_SP: dp_rd_data <= irq_stack_ptr;
        CRS_SEL_STATIC: dp_rd_data <= static_base_q;
        CRS_SEL_SP: dp_rd_data <= sp_sel ? user_stack_ptr : irq_stack_ptr;
        default: begin
          if (dp_rd_sel <= CRS_SEL_FRAME) begin
            dp_rd_data <= bank_regs[bank][dp_rd_sel[2:0]];
          end else begin
            dp_rd_data <= `CRS_W16_RESET;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read data, registered at the address phase or at the end of the wait
  // Unmapped reads zero
  logic [4:0] rd_sel;
  assign rd_sel = hreadyout ? crs_decode(haddr) : bus_wsel;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `CRS_W32_ZERO;
    end else if (rd_take) begin
      if (rd_sel < 5'h07) begin
        hrdata <= {16'h0000, bank_regs[bank][rd_sel[2:0]]};
      end else begin
        case (rd_sel)
          5'h07: hrdata <= {16'h0000, user_stack_ptr};
          5'h08: hrdata <= {16'h0000, irq_stack_ptr};
          5'h09: hrdata <= {16'h0000, static_base_q};
          5'h10: hrdata <= {12'h000, vtb_q};
          5'h11: hrdata <= {12'h000, pc_q};
          5'h12: hrdata <= {21'h000000, flags_q};
          default: hrdata <= `CRS_W32_ZERO;
        endcase
      end
    end
  end

endmodule : crs_register_set

// ===== testbench/crs_register_set_props.sv
`timescale 1ns/100ps
module crs_register_set_props
  import crs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pc_load,
  input wire crs_pkg::crs_addr_t pc_next,
  input wire logic vtb_load,
  input wire crs_pkg::crs_addr_t vtb_next,
  input wire logic alu_flags_en,
  input wire logic alu_carry,
  input wire crs_pkg::crs_word_t alu_result,
  input wire logic alu_byte,
  input wire logic alu_overflow,
  input wire logic dp_pair_wr_en,
  input wire logic [1:0] dp_pair_sel,
  input wire logic [31:0] dp_pair_data,
  input wire logic [31:0] data_pair_low_32,
  input wire crs_pkg::crs_addr_t program_counter,
  input wire crs_pkg::crs_addr_t vector_table_base,
  input wire crs_pkg::crs_flags_t cpu_flags
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mirrored outputs trail the register by one edge
  property p_pc;
    pc_load |-> ##2 program_counter == $past(pc_next, 2);
  endproperty
  a_pc: assert property (p_pc) else $error("pc load lost");
  property p_vtb;
    vtb_load |-> ##2 vector_table_base == $past(vtb_next, 2);
  endproperty
  a_vtb: assert property (p_vtb) else $error("vector base load lost");
  property p_carry;
    alu_flags_en |-> ##2 cpu_flags[0] == $past(alu_carry, 2);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_zero;
    alu_flags_en && !alu_byte |-> ##2 cpu_flags[2] == ($past(alu_result, 2) == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero wrong");
  property p_sign;
    alu_flags_en && !alu_byte |-> ##2 cpu_flags[3] == $past(alu_result[15], 2);
  endproperty
  a_sign: assert property (p_sign) else $error("sign wrong");
  property p_ovf;
    alu_flags_en |-> ##2 cpu_flags[5] == $past(alu_overflow, 2);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_pair;
    dp_pair_wr_en && dp_pair_sel == 2'h0 |-> ##2 data_pair_low_32 == $past(dp_pair_data, 2);
  endproperty
  a_pair: assert property (p_pair) else $error("pair write lost");
  property p_rst;
    $rose(hresetn) |-> cpu_flags == 11'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("flags not cleared");
endmodule : crs_register_set_props
bind crs_register_set crs_register_set_props u_props (.hclk, .hresetn, .pc_load, .pc_next,
  .vtb_load, .vtb_next, .alu_flags_en, .alu_carry, .alu_result, .alu_byte, .alu_overflow,
  .dp_pair_wr_en, .dp_pair_sel, .dp_pair_data, .data_pair_low_32, .program_counter,
  .vector_table_base, .cpu_flags);

// ===== testbench/crs_dp_model.sv
`timescale 1ns/100ps
module crs_dp_model
  import crs_pkg::*;
(
  input wire logic hclk,
  output logic dp_wr_en = 1'b0,
  output crs_pkg::crs_sel_e dp_wr_sel = CRS_SEL_DATA0,
  output crs_pkg::crs_lane_e dp_wr_lane = CRS_LANE_WORD,
  output crs_pkg::crs_word_t dp_wr_data = 16'h0000,
  output logic dp_pair_wr_en = 1'b0,
  output logic [1:0] dp_pair_sel = 2'h0,
  output logic [31:0] dp_pair_data = 32'h0000_0000,
  output logic pc_load = 1'b0,
  output crs_pkg::crs_addr_t pc_next = 20'h00000,
  output logic vtb_load = 1'b0,
  output crs_pkg::crs_addr_t vtb_next = 20'h00000,
  output logic alu_flags_en = 1'b0,
  output logic alu_carry = 1'b0,
  output crs_pkg::crs_word_t alu_result = 16'h0000,
  output logic alu_byte = 1'b0,
  output logic alu_overflow = 1'b0,
  output logic flags_load = 1'b0,
  output crs_pkg::crs_flags_t flags_next = 11'h000
);
  task automatic wr(input crs_sel_e s, input crs_lane_e l, input crs_word_t d);
    @(posedge hclk);
    dp_wr_en <= 1'b1;
    dp_wr_sel <= s;
    dp_wr_lane <= l;
    dp_wr_data <= d;
    @(posedge hclk);
    dp_wr_en <= 1'b0;
  endtask : wr
  task automatic pair(input logic [1:0] s, input logic [31:0] d);
    @(posedge hclk);
    dp_pair_wr_en <= 1'b1;
    dp_pair_sel <= s;
    dp_pair_data <= d;
    @(posedge hclk);
    dp_pair_wr_en <= 1'b0;
  endtask : pair
  task automatic alu(input logic c, input crs_word_t r, input logic b, input logic o);
    @(posedge hclk);
    alu_flags_en <= 1'b1;
    alu_carry <= c;
    alu_result <= r;
    alu_byte <= b;
    alu_overflow <= o;
    @(posedge hclk);
    alu_flags_en <= 1'b0;
  endtask : alu
  task automatic ld(input crs_addr_t p, input crs_addr_t v, input crs_flags_t f);
    @(posedge hclk);
    pc_load <= 1'b1;
    pc_next <= p;
    vtb_load <= 1'b1;
    vtb_next <= v;
    flags_load <= 1'b1;
    flags_next <= {f[10:2], 1'b0, f[0]};
    @(posedge hclk);
    pc_load <= 1'b0;
    vtb_load <= 1'b0;
    flags_load <= 1'b0;
  endtask : ld
endmodule : crs_dp_model

// ===== testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import crs_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, pr_lo, pr_hi, pr_a, rd, m;
  logic hreadyout, hresp, dp_wr_en, dp_pair_wr_en, pc_load, vtb_load;
  logic alu_flags_en, alu_carry, alu_byte, alu_overflow, flags_load;
  crs_sel_e dp_wr_sel;
  crs_sel_e dp_rd_sel = CRS_SEL_DATA1;
  crs_lane_e dp_wr_lane;
  crs_word_t dp_wr_data, alu_result, dp_rd_data, frame_base, static_base, sp;
  crs_addr_t pc_next, vtb_next, program_counter, vector_table_base;
  crs_flags_t flags_next, cpu_flags;
  logic [1:0] dp_pair_sel;
  logic [31:0] dp_pair_data;
  logic [15:0] ar[4] = '{16'h0000, 16'h8000, 16'h0080, 16'h0100};
  logic [2:0] af[4] = '{3'b000, 3'b101, 3'b010, 3'b110};
  logic [10:0] ef[4] = '{11'h084, 11'h0a9, 11'h088, 11'h085};
  int bad_count = 0;
  int num_checks = 0;
  always #12.5 hclk = ~hclk;
  crs_register_set DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dp_wr_en, .dp_wr_sel, .dp_wr_lane,
    .dp_wr_data, .dp_pair_wr_en, .dp_pair_sel, .dp_pair_data, .pc_load, .pc_next, .vtb_load,
    .vtb_next, .alu_flags_en, .alu_carry, .alu_result, .alu_byte, .alu_overflow, .flags_load,
    .flags_next, .dp_rd_sel, .dp_rd_data, .data_pair_low_32(pr_lo), .data_pair_high_32(pr_hi),
    .addr_pair_32(pr_a), .program_counter, .vector_table_base, .frame_base, .static_base,
    .active_stack_ptr(sp), .cpu_flags);
  crs_dp_model u_dp (.hclk, .dp_wr_en, .dp_wr_sel, .dp_wr_lane, .dp_wr_data, .dp_pair_wr_en,
    .dp_pair_sel, .dp_pair_data, .pc_load, .pc_next, .vtb_load, .vtb_next, .alu_flags_en,
    .alu_carry, .alu_result, .alu_byte, .alu_overflow, .flags_load, .flags_next);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk("response", 32'h0000_0000, 32'(hresp));
    rd = hrdata;
  endtask : bus
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask : rdc
  // Mirrored outputs need one more edge
  task automatic settle;
    @(posedge hclk);
    #1;
  endtask : settle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Last write lands in the flag word: bank 1, user stack, debug kept clear
    for (int i = 0; i <= 12; i++) begin
      m = (i == 12) ? 32'h0000_07ff : (i inside {7, 8}) ? 32'h000f_ffff : 32'h0000_ffff;
      bus(1'b1, 12'(i * 4), 32'hffff_fffd);
      rdc("reg", 12'(i * 4), 32'hffff_fffd & m);
    end
    settle;
    chk("static base", 32'h0000_fffd, static_base);
    chk("bank1 frame base", 32'h0000_0000, frame_base);
    rdc("bank1 data0", 12'h000, 32'h0000_0000);
    bus(1'b1, 12'h028, 32'h0000_2222);
    bus(1'b1, 12'h030, 32'h0000_0000);
    settle;
    chk("irq sp", 32'h0000_2222, sp);
    chk("frame base", 32'h0000_fffd, frame_base);
    rdc("bank0 data0", 12'h000, 32'h0000_fffd);
    bus(1'b1, 12'h030, 32'h0000_0080);
    settle;
    chk("user sp", 32'h0000_fffd, sp);
    @(posedge hclk);
    dp_rd_sel <= CRS_SEL_SP;
    u_dp.wr(CRS_SEL_SP, CRS_LANE_WORD, 16'h4321);
    settle;
    chk("stack write", 32'h0000_4321, sp);
    chk("stack read", 32'h0000_4321, dp_rd_data);
    @(posedge hclk);
    dp_rd_sel <= CRS_SEL_DATA1;
    rdc("unmapped", 12'h034, 32'h0000_0000);
    u_dp.wr(CRS_SEL_DATA0, CRS_LANE_LOW, 16'h1234);
    rdc("low lane", 12'h000, 32'h0000_ff34);
    u_dp.wr(CRS_SEL_DATA1, CRS_LANE_HIGH, 16'h5a5a);
    settle;
    chk("high lane", 32'h0000_5afd, dp_rd_data);
    u_dp.pair(2'h0, 32'h89ab_cdef);
    settle;
    chk("pair low", 32'h89ab_cdef, pr_lo);
    rdc("pair upper", 12'h008, 32'h0000_89ab);
    u_dp.pair(2'h1, 32'h0123_4567);
    settle;
    chk("pair high", 32'h0123_4567, pr_hi);
    u_dp.pair(2'h2, 32'hfedc_ba98);
    settle;
    chk("addr pair", 32'hfedc_ba98, pr_a);
    for (int i = 0; i < 4; i++) begin
      u_dp.alu(af[i][2], ar[i], af[i][1], af[i][0]);
      settle;
      chk("alu flags", 32'(ef[i]), 32'(cpu_flags));
    end
    u_dp.ld(20'habcde, 20'h54321, 11'h012);
    settle;
    chk("pc", 32'h000a_bcde, program_counter);
    chk("vector base", 32'h0005_4321, vector_table_base);
    chk("flag load", 32'h0000_0010, cpu_flags);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk("flags after reset", 32'h0000_0000, cpu_flags);
    rdc("data0 after reset", 12'h000, 32'h0000_0000);
    finish_test;
  end
  // Run needs about 150 cycles
  initial begin
    #(3000 * 25);
    bad_count++;
    finish_test;
  end
endmodule : tb
